// ### iifcm_device.sv
// Device end: link capture, elastic FIFO, two filter and mixer stages
`timescale 1ns/1ps
`default_nettype none
module iifcm_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Fill side
	input wire logic wr_valid_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	output logic wr_ready_o,
	// Drain side
	output logic rd_valid_o,
	output logic [WIDTH-1:0] rd_data_o,
	input wire logic rd_ready_i
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic wr_fire;
	logic rd_fire;

	assign wr_ready_o = count_reg != (AW+1)'(DEPTH);
	assign rd_valid_o = count_reg != '0;
	assign rd_data_o = mem[rd_ptr_reg];
	assign wr_fire = wr_valid_i && wr_ready_o;
	assign rd_fire = rd_ready_i && rd_valid_o;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	always_ff @(posedge clock_i) begin
		if (wr_fire) begin
			mem[wr_ptr_reg] <= wr_data_i;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (wr_fire) begin
				wr_ptr_reg <= bump(wr_ptr_reg);
			end
			if (rd_fire) begin
				rd_ptr_reg <= bump(rd_ptr_reg);
			end
			if (wr_fire && !rd_fire) begin
				count_reg <= count_reg + (AW+1)'(1);
			end else if (rd_fire && !wr_fire) begin
				count_reg <= count_reg - (AW+1)'(1);
			end
		end
	end

endmodule // iifcm_fifo

module iifcm_device import iifcm_pkg::*; #(
	parameter int CAPTURE_DELAY = IIFCM_CAPTURE_DLY,
	parameter int FIFO_DEPTH = IIFCM_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Link
	iifcm_link_if.device link,
	// Configuration
	input wire logic [1:0] interp_mode_i,
	input wire logic first_hp_i,
	input wire logic second_hp_i,
	input wire logic [1:0] first_mixer_select_i,
	input wire logic [1:0] second_mixer_select_i,
	input wire logic sync_clears_filters_i,
	// Converter side
	output logic [15:0] channel_a_output_o,
	output logic [15:0] channel_b_output_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	// Status
	output logic link_ready_o,
	output logic overrun_o,
	output logic sync_event_o
);

	// ******************************************
	// Arithmetic helpers
	// ******************************************
	function automatic logic [15:0] sat16(input logic signed [39:0] v);
		if (v > 40'sh0000007fff) begin
			sat16 = 16'h7fff;
		end else if (v < -40'sh0000008000) begin
			sat16 = 16'h8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction

	// Negating the most negative code would wrap, so it clips instead
	function automatic logic [15:0] neg16(input logic [15:0] x);
		neg16 = (x == 16'h8000) ? 16'h7fff : 16'(-x);
	endfunction

	// Phase 0 is the centre tap, phase 1 the odd-tap pair sum
	function automatic logic [15:0] fir_out(input iifcm_hist_t h,
			input logic phase, input logic hp);
		logic signed [39:0] acc;
		logic signed [15:0] p;
		logic signed [15:0] q;
		logic signed [16:0] s;
		logic [15:0] r;
		logic signed [39:0] c;
		acc = '0;
		for (int j = 0; j < IIFCM_PAIRS; j++) begin
			p = h[IIFCM_CENTRE_IDX - j];
			q = h[IIFCM_CENTRE_IDX + 1 + j];
			s = {p[15], p} + {q[15], q};
			acc = acc + 40'(s * IIFCM_COEF[j]);
		end
		// Shift by 14 gives unity gain after zero stuffing
		r = sat16(acc >>> IIFCM_GAIN_SHIFT);
		c = 40'($signed(h[IIFCM_CENTRE_IDX]) * IIFCM_CENTRE);
		if (!phase) begin
			fir_out = sat16(c >>> IIFCM_GAIN_SHIFT);
		end else begin
			fir_out = hp ? neg16(r) : r;
		end
	endfunction

	function automatic logic [31:0] mix(input logic [1:0] sel,
			input logic [1:0] ph, input logic [15:0] a, input logic [15:0] b);
		mix = {a, b};
		unique case (sel)
			IIFCM_MIX_PASS: mix = {a, b};
			IIFCM_MIX_HALF: mix = ph[0] ? {neg16(a), neg16(b)} : {a, b};
			IIFCM_MIX_PLUS: begin
				unique case (ph)
					2'h0: mix = {a, b};
					2'h1: mix = {neg16(b), a};
					2'h2: mix = {neg16(a), neg16(b)};
					2'h3: mix = {b, neg16(a)};
				endcase
			end
			IIFCM_MIX_MINUS: begin
				unique case (ph)
					2'h0: mix = {a, b};
					2'h1: mix = {b, neg16(a)};
					2'h2: mix = {neg16(a), neg16(b)};
					2'h3: mix = {neg16(b), a};
				endcase
			end
		endcase
	endfunction

	function automatic iifcm_hist_t push(input iifcm_hist_t h,
			input logic clr, input logic [15:0] v);
		push = clr ? iifcm_hist_t'(v) : {h[IIFCM_HIST-2:0], v};
	endfunction

	// ******************************************
	// Link capture
	// ******************************************
	logic [17:0] meta_reg;
	logic [17:0] pin_reg;
	logic dclk_last_reg;
	logic [7:0] edge_dly_reg;
	logic capture;
	logic wr_ready;
	logic rd_valid;
	logic rd_ready;
	iifcm_word_s word;

	assign capture = edge_dly_reg[CAPTURE_DELAY-1];

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_reg <= '0;
			pin_reg <= '0;
			dclk_last_reg <= 1'b0;
			edge_dly_reg <= 8'h00;
		end else begin
			meta_reg <= {link.half_rate_data_clock, link.sync_enable_lane,
				link.data};
			pin_reg <= meta_reg;
			dclk_last_reg <= pin_reg[17];
			// Delay line on both edges lets the data settle first
			edge_dly_reg <= {edge_dly_reg[6:0],
				pin_reg[17] ^ dclk_last_reg};
		end
	end

	// The link cannot stall, so a full FIFO drops and flags the word
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			overrun_o <= 1'b0;
			link_ready_o <= 1'b0;
		end else begin
			link_ready_o <= wr_ready;
			if (capture && !wr_ready) begin
				overrun_o <= 1'b1;
			end
		end
	end

	iifcm_fifo #(
		.WIDTH(IIFCM_WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.wr_valid_i(capture),
		.wr_data_i(pin_reg[16:0]),
		.wr_ready_o(wr_ready),
		.rd_valid_o(rd_valid),
		.rd_data_o(word),
		.rd_ready_i(rd_ready)
	);

	// ******************************************
	// Sequencing
	// ******************************************
	iifcm_state_e state_reg;
	logic p1_reg;
	logic p2_reg;
	logic [1:0] ph1_reg;
	logic [1:0] ph2_reg;
	logic sync_prev_reg;
	logic [15:0] a_hold_reg;
	iifcm_hist_t s1a_reg, s1b_reg, s2a_reg, s2b_reg;
	logic is_x1;
	logic is_x4;
	logic out_free;
	logic rd_fire;
	logic sync_ev;
	logic hist_clr;
	logic [15:0] word_val;
	logic [31:0] first_mix;
	logic [31:0] second_mix;
	logic [15:0] first_stage_a_out;
	logic [15:0] first_stage_b_out;

	assign is_x1 = interp_mode_i == IIFCM_X1;
	assign is_x4 = interp_mode_i[1];
	assign out_free = !out_valid_o || out_ready_i;
	assign rd_ready = (state_reg == IIFCM_ST_READ_A && (!is_x1 || out_free))
		|| state_reg == IIFCM_ST_READ_B;
	assign rd_fire = rd_ready && rd_valid;
	assign word_val = word.sync ? word.data : IIFCM_ZERO;
	assign sync_ev = rd_fire && word.sync && !sync_prev_reg;
	assign hist_clr = sync_ev && sync_clears_filters_i;
	assign first_mix = mix(first_mixer_select_i, ph1_reg,
		fir_out(s1a_reg, p1_reg, first_hp_i),
		fir_out(s1b_reg, p1_reg, first_hp_i));
	assign first_stage_a_out = first_mix[31:16];
	assign first_stage_b_out = first_mix[15:0];
	assign second_mix = mix(second_mixer_select_i, ph2_reg,
		fir_out(s2a_reg, p2_reg, second_hp_i),
		fir_out(s2b_reg, p2_reg, second_hp_i));

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= IIFCM_ST_READ_A;
			p1_reg <= 1'b0;
			p2_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				IIFCM_ST_READ_A: if (rd_fire && !is_x1) begin
					state_reg <= IIFCM_ST_READ_B;
				end
				IIFCM_ST_READ_B: if (rd_fire) begin
					state_reg <= is_x4 ? IIFCM_ST_FIRST : IIFCM_ST_EMIT;
					p1_reg <= 1'b0;
					p2_reg <= 1'b0;
				end
				IIFCM_ST_FIRST: begin
					state_reg <= IIFCM_ST_EMIT;
					p2_reg <= 1'b0;
				end
				IIFCM_ST_EMIT: if (out_free) begin
					if (!p2_reg) begin
						p2_reg <= 1'b1;
					end else if (is_x4 && !p1_reg) begin
						p1_reg <= 1'b1;
						state_reg <= IIFCM_ST_FIRST;
					end else begin
						state_reg <= IIFCM_ST_READ_A;
					end
				end
			endcase
		end
	end

	// ******************************************
	// Filter histories
	// ******************************************
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			a_hold_reg <= IIFCM_ZERO;
			s1a_reg <= '0;
			s1b_reg <= '0;
			s2a_reg <= '0;
			s2b_reg <= '0;
		end else begin
			if (hist_clr) begin
				s1a_reg <= '0;
				s1b_reg <= '0;
				s2a_reg <= '0;
				s2b_reg <= '0;
			end
			if (state_reg == IIFCM_ST_READ_A && rd_fire) begin
				a_hold_reg <= word_val;
			end
			if (state_reg == IIFCM_ST_READ_B && rd_fire) begin
				if (is_x4) begin
					s1a_reg <= push(s1a_reg, hist_clr, a_hold_reg);
					s1b_reg <= push(s1b_reg, hist_clr, word_val);
				end else begin
					s2a_reg <= push(s2a_reg, hist_clr, a_hold_reg);
					s2b_reg <= push(s2b_reg, hist_clr, word_val);
				end
			end
			if (state_reg == IIFCM_ST_FIRST) begin
				s2a_reg <= push(s2a_reg, 1'b0, first_stage_a_out);
				s2b_reg <= push(s2b_reg, 1'b0, first_stage_b_out);
			end
		end
	end

	// ******************************************
	// Mixer phases and sync tracking
	// ******************************************
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ph1_reg <= 2'h0;
			ph2_reg <= 2'h0;
			sync_prev_reg <= 1'b0;
			sync_event_o <= 1'b0;
		end else begin
			sync_event_o <= sync_ev;
			if (rd_fire) begin
				sync_prev_reg <= word.sync;
			end
			if (sync_ev) begin
				ph1_reg <= 2'h0;
				ph2_reg <= 2'h0;
			end else begin
				if (state_reg == IIFCM_ST_FIRST) begin
					ph1_reg <= ph1_reg + 2'h1;
				end
				if (state_reg == IIFCM_ST_EMIT && out_free) begin
					ph2_reg <= ph2_reg + 2'h1;
				end
			end
		end
	end

	// ******************************************
	// Converter outputs
	// ******************************************
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			channel_a_output_o <= IIFCM_ZERO;
			channel_b_output_o <= IIFCM_ZERO;
			out_valid_o <= 1'b0;
		end else if (state_reg == IIFCM_ST_EMIT && out_free) begin
			channel_a_output_o <= second_mix[31:16];
			channel_b_output_o <= second_mix[15:0];
			out_valid_o <= 1'b1;
		end else if (state_reg == IIFCM_ST_READ_A && is_x1 && rd_fire) begin
			channel_a_output_o <= word_val;
			channel_b_output_o <= IIFCM_ZERO;
			out_valid_o <= 1'b1;
		end else if (out_ready_i) begin
			out_valid_o <= 1'b0;
		end
	end

endmodule // iifcm_device
`default_nettype wire

// ### iifcm_pkg.sv
// Constants and types shared by both ends of the interpolating mixer link
package iifcm_pkg;

	// ******************************************
	// Widths and sizes
	// ******************************************
	localparam int IIFCM_DATA_W = 16;
	localparam int IIFCM_WORD_W = 17;
	localparam int IIFCM_FIFO_DEPTH = 32;
	localparam int IIFCM_TAPS = 47;
	localparam int IIFCM_HIST = (IIFCM_TAPS + 1) / 2;
	localparam int IIFCM_PAIRS = IIFCM_HIST / 2;
	localparam int IIFCM_CENTRE_IDX = IIFCM_PAIRS - 1;
	localparam int IIFCM_GAIN_SHIFT = 14;
	localparam int IIFCM_ACC_W = 40;
	localparam int IIFCM_GROUP = 4;

	// ******************************************
	// Timing
	// ******************************************
	localparam int IIFCM_CLK_PERIOD_NS = 50;
	localparam int IIFCM_LINK_PERIOD_NS = 400;
	localparam int IIFCM_LINK_HALF_CYC =
		IIFCM_LINK_PERIOD_NS / (2 * IIFCM_CLK_PERIOD_NS);
	localparam int IIFCM_CAPTURE_DLY = 1;

	// ******************************************
	// Filter taps, nearest pair first; even taps are zero
	// ******************************************
	localparam logic signed [15:0] IIFCM_CENTRE = 16'h4000;
	localparam logic signed [15:0] IIFCM_COEF [IIFCM_PAIRS] = '{
		16'h2880, 16'hf321, 16'h0703, 16'hfbae, 16'h02c0, 16'hfe44,
		16'h0110, 16'hff62, 16'h0055, 16'hffd6, 16'h0012, 16'hfffb};

	// ******************************************
	// Reset values
	// ******************************************
	localparam logic [15:0] IIFCM_ZERO = 16'h0000;

	// ******************************************
	// Types
	// ******************************************
	typedef enum logic [1:0] {
		IIFCM_X1 = 2'b00,
		IIFCM_X2 = 2'b01,
		IIFCM_X4 = 2'b10
	} iifcm_interp_e;

	typedef enum logic [1:0] {
		IIFCM_MIX_PASS = 2'b00,
		IIFCM_MIX_HALF = 2'b01,
		IIFCM_MIX_PLUS = 2'b10,
		IIFCM_MIX_MINUS = 2'b11
	} iifcm_mix_e;

	typedef enum logic [1:0] {
		IIFCM_ST_READ_A = 2'b00,
		IIFCM_ST_READ_B = 2'b01,
		IIFCM_ST_FIRST = 2'b10,
		IIFCM_ST_EMIT = 2'b11
	} iifcm_state_e;

	typedef logic [IIFCM_HIST-1:0][15:0] iifcm_hist_t;

	typedef struct packed {
		logic sync;
		logic [15:0] data;
	} iifcm_word_s;

endpackage

// ### iifcm_link_if.sv
// Link wires between the sample source and the interpolating device
`timescale 1ns/1ps
`default_nettype none
interface iifcm_link_if;
	logic [15:0] data;
	logic sync_enable_lane;
	logic half_rate_data_clock;

	modport source (
		output data,
		output sync_enable_lane,
		output half_rate_data_clock
	);

	modport device (
		input data,
		input sync_enable_lane,
		input half_rate_data_clock
	);
endinterface // iifcm_link_if
`default_nettype wire

// ### iifcm_source.sv
// Sample source end: four-sample parallel load, one word per clock edge
`timescale 1ns/1ps
`default_nettype none
module iifcm_source import iifcm_pkg::*; #(
	parameter int HALF_CYC = IIFCM_LINK_HALF_CYC
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Link
	iifcm_link_if.source link,
	// User side
	input wire logic group_valid_i,
	input wire logic [IIFCM_GROUP-1:0][15:0] group_data_i,
	input wire logic [IIFCM_GROUP-1:0] group_sync_i,
	output logic group_ready_o
);

	logic [7:0] div_cnt_reg;
	logic tick;
	logic [IIFCM_GROUP-1:0][15:0] hold_data_reg;
	logic [IIFCM_GROUP-1:0] hold_sync_reg;
	logic hold_full_reg;
	logic hold_full_next;
	logic [IIFCM_GROUP-1:0][15:0] shift_data_reg;
	logic [IIFCM_GROUP-1:0] shift_sync_reg;
	logic [2:0] remain_reg;
	logic group_ready_reg;
	logic dclk_reg;
	logic [15:0] data_reg;
	logic sync_reg;
	logic accept;
	logic load;

	assign tick = div_cnt_reg == 8'(HALF_CYC - 1);
	assign accept = group_valid_i && group_ready_reg;
	assign load = tick && remain_reg == 3'h0 && hold_full_reg;
	assign hold_full_next = load ? 1'b0 : (accept ? 1'b1 : hold_full_reg);
	assign group_ready_o = group_ready_reg;
	assign link.data = data_reg;
	assign link.sync_enable_lane = sync_reg;
	assign link.half_rate_data_clock = dclk_reg;

	// ******************************************
	// Clock divider
	// ******************************************
	// The lane keeps toggling when idle so the capture delay stays steady
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_cnt_reg <= 8'h00;
			dclk_reg <= 1'b0;
		end else if (tick) begin
			div_cnt_reg <= 8'h00;
			dclk_reg <= ~dclk_reg;
		end else begin
			div_cnt_reg <= div_cnt_reg + 8'h01;
		end
	end

	// ******************************************
	// Group holding register
	// ******************************************
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hold_full_reg <= 1'b0;
			group_ready_reg <= 1'b0;
			hold_data_reg <= '0;
			hold_sync_reg <= '0;
		end else begin
			hold_full_reg <= hold_full_next;
			group_ready_reg <= !hold_full_next;
			if (accept) begin
				hold_data_reg <= group_data_i;
				hold_sync_reg <= group_sync_i;
			end
		end
	end

	// ******************************************
	// Parallel load and serial shift
	// ******************************************
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			shift_data_reg <= '0;
			shift_sync_reg <= '0;
			remain_reg <= 3'h0;
			data_reg <= IIFCM_ZERO;
			sync_reg <= 1'b0;
		end else if (tick) begin
			if (load) begin
				data_reg <= hold_data_reg[0];
				sync_reg <= hold_sync_reg[0];
				shift_data_reg <= {IIFCM_ZERO, hold_data_reg[3:1]};
				shift_sync_reg <= {1'b0, hold_sync_reg[3:1]};
				remain_reg <= 3'(IIFCM_GROUP - 1);
			end else if (remain_reg != 3'h0) begin
				data_reg <= shift_data_reg[0];
				sync_reg <= shift_sync_reg[0];
				shift_data_reg <= {IIFCM_ZERO, shift_data_reg[3:1]};
				shift_sync_reg <= {1'b0, shift_sync_reg[3:1]};
				remain_reg <= remain_reg - 3'h1;
			end else begin
				// Underrun sends zeros with sync low
				data_reg <= IIFCM_ZERO;
				sync_reg <= 1'b0;
			end
		end
	end

endmodule // iifcm_source
`default_nettype wire

// ### iifcm_link_monitor.sv
// Link checker: wire-level timing of the sample source end
`timescale 1ns/1ps
`default_nettype none
module iifcm_link_monitor import iifcm_pkg::*; #(
	parameter int HALF_CYC = IIFCM_LINK_HALF_CYC
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Link
	input wire logic [15:0] data,
	input wire logic sync_enable_lane,
	input wire logic half_rate_data_clock
);
	// ****************************************
	// Cycles since the last clock lane toggle
	// ****************************************
	logic lane_d_reg;
	logic seen_reg;
	logic [7:0] gap_reg;
	logic toggle;
	assign toggle = half_rate_data_clock != lane_d_reg;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) lane_d_reg <= 1'b0;
		else lane_d_reg <= half_rate_data_clock;
	end
	// Phase of the first toggle is free, so period checks wait for one
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) seen_reg <= 1'b0;
		else if (toggle) seen_reg <= 1'b1;
	end
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) gap_reg <= 8'h00;
		else if (toggle) gap_reg <= 8'h00;
		else if (gap_reg != 8'hff) gap_reg <= gap_reg + 8'h01;
	end
	// ****************************************
	// Assertions
	// ****************************************
	a_lane_half_period: assert property (seen_reg && toggle |-> gap_reg == HALF_CYC - 1)
		else $error("Data clock lane half period wrong");
	a_lane_no_stall: assert property (seen_reg |-> gap_reg < HALF_CYC)
		else $error("Data clock lane stopped toggling");
	a_lane_starts: assert property ($rose(nrst_i) |-> ##[1:10] toggle)
		else $error("Data clock lane did not start");
	a_reset_idle_lane: assert property ($rose(nrst_i) |-> !half_rate_data_clock && !sync_enable_lane && data == 16'h0000)
		else $error("Link not idle out of reset");
	a_data_on_edge: assert property ($changed(data) |-> $changed(half_rate_data_clock))
		else $error("Data changed away from a clock lane edge");
	a_sync_on_edge: assert property ($changed(sync_enable_lane) |-> $changed(half_rate_data_clock))
		else $error("Sync lane changed away from a clock lane edge");
	a_both_edges_used: assert property ($rose(half_rate_data_clock) |-> ##[1:8] $fell(half_rate_data_clock))
		else $error("Clock lane has no falling edge");
	a_word_holds: assert property ($changed(half_rate_data_clock) |=> ($stable(data) && $stable(sync_enable_lane)) [*3])
		else $error("Word not held for a half period");
endmodule // iifcm_link_monitor
`default_nettype wire

// ### testbench.sv
// Self-checking bench: source and device joined over the link
`timescale 1ns/1ps
`default_nettype none
module testbench import iifcm_pkg::*;;
	localparam int HALF = IIFCM_LINK_HALF_CYC;
	logic clock_i, nrst_i, hp1, hp2, clr, out_valid, out_ready, link_ready;
	logic overrun, sync_event, group_valid, group_ready, ready_hold, stall_en;
	logic [1:0] interp_mode, m1, m2, stall_cnt;
	logic [15:0] cha, chb;
	logic [15:0] qa[$];
	logic [15:0] qb[$];
	logic [3:0][15:0] group_data;
	logic [3:0] group_sync;
	int fail_count, checks_done, ev_count;
	int coef [12] = '{10368, -3295, 1795, -1106, 704, -444, 272, -158, 85, -42, 18, -5};
	iifcm_link_if u_iifcm_link_if ();
	iifcm_source #(.HALF_CYC(HALF)) u_iifcm_source (.clock_i(clock_i), .nrst_i(nrst_i),
		.link(u_iifcm_link_if), .group_valid_i(group_valid), .group_data_i(group_data),
		.group_sync_i(group_sync), .group_ready_o(group_ready));
	iifcm_device #(.FIFO_DEPTH(32)) u_iifcm_device (.clock_i(clock_i), .nrst_i(nrst_i),
		.link(u_iifcm_link_if), .interp_mode_i(interp_mode), .first_hp_i(hp1),
		.second_hp_i(hp2), .first_mixer_select_i(m1), .second_mixer_select_i(m2),
		.sync_clears_filters_i(clr), .channel_a_output_o(cha), .channel_b_output_o(chb),
		.out_valid_o(out_valid), .out_ready_i(out_ready), .link_ready_o(link_ready),
		.overrun_o(overrun), .sync_event_o(sync_event));
	iifcm_link_monitor #(.HALF_CYC(HALF)) u_iifcm_link_monitor (.clock_i(clock_i),
		.nrst_i(nrst_i), .data(u_iifcm_link_if.data),
		.sync_enable_lane(u_iifcm_link_if.sync_enable_lane),
		.half_rate_data_clock(u_iifcm_link_if.half_rate_data_clock));
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	// ****************************************
	// Consumer with optional stalls, output capture
	// ****************************************
	always @(posedge clock_i) begin
		stall_cnt <= stall_cnt + 2'd1;
		out_ready <= ready_hold && !(stall_en && stall_cnt == 2'd0);
		if (nrst_i && out_valid && out_ready) begin
			qa.push_back(cha);
			qb.push_back(chb);
		end
		if (nrst_i && sync_event) ev_count++;
	end
	task automatic chk(input string name, input int e, input logic [15:0] got);
		logic [15:0] ev;
		ev = e[15:0];
		checks_done++;
		if (got !== ev) begin
			$display("MISMATCH %s expected %h seen %h", name, ev, got);
			fail_count++;
		end
	endtask
	function automatic int sel(int ph, int x, int y);
		return ph == 0 ? x : ph == 1 ? y : ph == 2 ? -x : -y;
	endfunction
	function automatic int mix(int ph, int a, int b, logic [1:0] m, logic ch);
		int v;
		v = ch ? b : a;
		case (m)
			2'b00: return v;
			2'b01: return ph[0] ? -v : v;
			2'b10: return ch ? sel(ph, b, a) : sel(ph, a, -b);
			default: return ch ? sel(ph, b, -a) : sel(ph, a, b);
		endcase
	endfunction
	// Impulse of 16384 makes each odd-phase output equal one tap
	function automatic int imp(int n);
		int k;
		k = n / 2;
		if (n[0] == 1'b0) return (k == 11) ? 16384 : 0;
		return coef[(k <= 11) ? 11 - k : k - 12];
	endfunction
	// ****************************************
	// Access tasks
	// ****************************************
	task automatic start(input logic [1:0] im, input logic [1:0] a1, input logic h1,
		input logic [1:0] a2, input logic h2);
		nrst_i <= 1'b0;
		interp_mode <= im;
		m1 <= a1;
		hp1 <= h1;
		m2 <= a2;
		hp2 <= h2;
		clr <= im[0];
		repeat (20) @(posedge clock_i);
		qa.delete();
		qb.delete();
		ev_count = 0;
		nrst_i <= 1'b1;
	endtask
	task automatic send_group(input logic [3:0][15:0] d, input logic [3:0] s);
		int i;
		group_data <= d;
		group_sync <= s;
		group_valid <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clock_i);
			if (group_ready === 1'b1) break;
		end
	endtask
	task automatic wait_out(input int n);
		int i;
		for (i = 0; i < 3000 && qa.size() < n; i++) @(posedge clock_i);
		checks_done++;
		if (qa.size() < n) begin
			$display("MISMATCH output count expected %0d seen %0d", n, qa.size());
			fail_count++;
		end
	endtask
	// ****************************************
	// Tests
	// ****************************************
	task automatic t1x();
		int i;
		logic [7:0][15:0] wd;
		wd = {16'h7ffc, 16'h7ffd, 16'h7ffe, 16'h7fff, 16'h8004, 16'h8003, 16'h8002, 16'h8001};
		start(2'b00, 2'b01, 1'b1, 2'b10, 1'b1);
		stall_en <= 1'b1;
		send_group(wd[3:0], 4'b0011);
		send_group(wd[7:4], 4'b1111);
		group_valid <= 1'b0;
		wait_out(8);
		for (i = 0; i < 8; i++) begin
			chk("full rate A", (i == 2 || i == 3) ? 0 : wd[i], qa[i]);
			chk("full rate B", 0, qb[i]);
		end
		chk("sync events", 2, ev_count[15:0]);
		$display("Test full rate done");
	endtask
	task automatic t2x(input logic [1:0] a2, input logic h2);
		int n, ra, rb;
		start(2'b01, 2'b11, 1'b1, a2, h2);
		stall_en <= 1'b1;
		send_group({16'h0000, 16'h0000, 16'h2000, 16'h4000}, 4'hf);
		group_valid <= 1'b0;
		wait_out(48);
		for (n = 0; n < 48 && n < qa.size(); n++) begin
			ra = imp(n);
			rb = (ra * 8192) >>> 14;
			if (h2 && n[0]) begin
				ra = -ra;
				rb = -rb;
			end
			chk("channel A", mix(n % 4, ra, rb, a2, 1'b0), qa[n]);
			chk("channel B", mix(n % 4, ra, rb, a2, 1'b1), qb[n]);
		end
		chk("overrun", 0, {15'h0000, overrun});
		chk("sync events", 1, ev_count[15:0]);
		$display("Test 2x mixer %0d high pass %0d done", a2, h2);
	endtask
	// Alternating first mixer turns DC into an Fs/2 tone at the
	// second filter: its even outputs alternate, odd outputs cancel
	task automatic t4x(input logic [1:0] a1);
		int n, ex;
		start(2'b10, a1, 1'b0, 2'b00, 1'b0);
		stall_en <= 1'b0;
		repeat (32) send_group({4{16'h4000}}, 4'hf);
		group_valid <= 1'b0;
		wait_out(256);
		for (n = 160; n < 256 && n < qa.size(); n++) begin
			ex = n[1] ? 16384 : -16384;
			ex = a1[0] ? (n[0] ? 0 : ex) : 16384;
			chk("4x A", ex, qa[n]);
			chk("4x B", ex, qb[n]);
		end
		$display("Test 4x first mixer %0d done", a1);
	endtask
	task automatic tfull();
		int i;
		start(2'b00, 2'b00, 1'b0, 2'b00, 1'b0);
		ready_hold <= 1'b0;
		repeat (200) @(posedge clock_i);
		chk("link ready", 0, {15'h0000, link_ready});
		chk("overrun", 1, {15'h0000, overrun});
		ready_hold <= 1'b1;
		for (i = 0; i < 300 && out_valid !== 1'b0; i++) @(posedge clock_i);
		chk("drained valid", 0, {15'h0000, out_valid});
		chk("link ready", 1, {15'h0000, link_ready});
		chk("overrun sticky", 1, {15'h0000, overrun});
		$display("Test FIFO fill and drain done");
	endtask
	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		int i;
		nrst_i = 1'b0;
		{interp_mode, m1, m2, hp1, hp2, clr} = '0;
		{group_valid, group_data, group_sync} = '0;
		{out_ready, ready_hold, stall_en, stall_cnt} = '0;
		fail_count = 0;
		checks_done = 0;
		ev_count = 0;
		@(posedge clock_i);
		ready_hold <= 1'b1;
		t1x();
		for (i = 0; i < 4; i++) t2x(i[1:0], 1'b0);
		t2x(2'b00, 1'b1);
		t4x(2'b00);
		t4x(2'b01);
		tfull();
		end_of_test();
	end
	// Whole run needs about 2500 cycles; this allows sixteen times that
	initial begin
		#2000000;
		fail_count++;
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
